// *** design/risc_instruction_format_decoder.sv ***
// Instruction word decoder with cycle pacing and an AXI4-Lite control port
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "isa_defines.svh"

module risc_instruction_format_decoder (
	input wire logic clk,
	input wire logic arst_n,
	input wire isa_pkg::axi_req_t axi_req,
	output var isa_pkg::axi_rsp_t axi_rsp,
	input wire logic [13:0] fetch_word,
	output logic fetch_take,
	output logic [6:0] rd_addr,
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] alu_result,
	input wire logic [2:0] alu_flags,
	output var isa_pkg::exec_t ex
);
	import isa_pkg::*;

	// ==========================================
	// Reset release
	logic [1:0] rst_sync_q;
	logic rst_n;
	state_t st_q;
	state_t st_d;
	logic tick;
	logic pc_chg;
	logic skip_taken;
	logic [2:0] fmask;
	logic [2:0] fval;
	logic [7:0] result;
	logic [7:0] rmw;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ==========================================
	// Decode helpers
	function automatic grp_t grp_of(input logic [13:0] w);
		if (w[13:12] == 2'b00) begin
			return GRP_BYTE;
		end else if (w[13:12] == 2'b01) begin
			return GRP_BIT;
		end
		return GRP_LIT;
	endfunction

	// Returns, jumps, calls and writes to the low PC byte
	function automatic logic changes_pc(input logic [13:0] w);
		logic ret;
		ret = (w[13:4] == 10'h000) && (w[3:1] == 3'b100);
		return (w[13:12] == 2'b10) || (w[13:10] == 4'b1101) || ret ||
			((grp_of(w) == GRP_BYTE) && w[`DEST_BIT] && (w[6:0] == `ADDR_PCL));
	endfunction

	// Flags touched, as {Z, DC, C}; x bits of literal codes are masked off
	function automatic logic [2:0] flag_mask(input logic [13:0] w);
		logic [2:0] m;
		m = 3'b000;
		casez (w[13:8])
			6'b000111, 6'b000010: m = 3'b111;
			6'b00110?: m = 3'b001;
			6'b000000, 6'b00111?, 6'b001011: m = 3'b000;
			6'b00????: m = 3'b100;
			6'b11111?, 6'b11110?: m = 3'b111;
			6'b111000, 6'b111001, 6'b111010: m = 3'b100;
			default: m = 3'b000;
		endcase
		return m;
	endfunction

	// ==========================================
	// Datapath terms
	assign tick = st_q.run && (st_q.ph == PH_Q4);
	assign fetch_take = tick;
	assign rd_addr = fetch_word[`REG_HI:0];

	always_comb begin
		rmw = file_rd_data;
		rmw[fetch_word[`POS_HI:`POS_LO]] = fetch_word[10];
		skip_taken = 1'b0;
		if (grp_of(fetch_word) == GRP_BIT && fetch_word[11]) begin
			skip_taken = file_rd_data[fetch_word[`POS_HI:`POS_LO]] == fetch_word[10];
		end else if (fetch_word[13:8] == 6'b001011 || fetch_word[13:8] == 6'b001111) begin
			skip_taken = (alu_result == 8'h00);
		end
		pc_chg = changes_pc(fetch_word);
		fmask = flag_mask(fetch_word);
		fval = alu_flags;
		result = alu_result;
		if (grp_of(fetch_word) == GRP_BIT) begin
			result = rmw;
		end else if (fetch_word[13:8] == 6'b000001) begin
			result = 8'h00;
			fval = 3'b100;
		end else if (fetch_word[13:11] == 3'b110) begin
			result = fetch_word[`IMM8_HI:0];
		end
		if (fetch_word[`REG_HI:0] == `ADDR_STATUS) begin
			result[2:0] = (result[2:0] & ~fmask) | (fval & fmask);
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.ex.valid = 1'b0;
		if (st_q.run) begin
			case (st_q.ph)
				PH_Q1: st_d.ph = PH_Q2;
				PH_Q2: st_d.ph = PH_Q3;
				PH_Q3: st_d.ph = PH_Q4;
				default: st_d.ph = PH_Q1;
			endcase
		end
		if (tick) begin
			st_d.cyc = st_q.cyc + 32'h1;
			if (st_q.flush) begin
				st_d.ex = '0;
				st_d.ex.valid = 1'b1;
				st_d.ex.idle = 1'b1;
				st_d.flush = 1'b0;
			end else begin
				st_d.last_w = fetch_word;
				st_d.ex.valid = 1'b1;
				st_d.ex.idle = (fetch_word[13:7] == 7'h00) && (fetch_word[4:0] == 5'h00);
				st_d.ex.grp = grp_of(fetch_word);
				st_d.ex.opcode = fetch_word[`OP_HI:`OP_LO];
				st_d.ex.to_file = fetch_word[`DEST_BIT];
				st_d.ex.reg_num = fetch_word[`REG_HI:0];
				st_d.ex.flag_pos = fetch_word[`POS_HI:`POS_LO];
				st_d.ex.imm8 = fetch_word[`IMM8_HI:0];
				st_d.ex.imm11 = fetch_word[`IMM11_HI:0];
				st_d.ex.wr_data = result;
				st_d.ex.wr_file = 1'b0;
				st_d.ex.acc_wr = 1'b0;
				if (grp_of(fetch_word) == GRP_BYTE) begin
					st_d.ex.wr_file = fetch_word[`DEST_BIT];
					st_d.ex.acc_wr = !fetch_word[`DEST_BIT] && (fetch_word[13:8] != 6'h00);
				end else if (grp_of(fetch_word) == GRP_BIT) begin
					st_d.ex.wr_file = !fetch_word[11];
				end else begin
					st_d.ex.acc_wr = fetch_word[13:12] == 2'b11;
				end
				st_d.ex.two_cycle = pc_chg || skip_taken;
				st_d.flush = pc_chg || skip_taken;
			end
		end
		// Bus write side: address and data taken in either order
		if (axi_req.awvalid && axi_rsp.awready) begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = {axi_req.awaddr[7:2], 2'b00};
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			st_d.w_got = 1'b1;
			st_d.wdata = axi_req.wdata;
			st_d.wstrb = axi_req.wstrb;
		end
		if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `RESP_OKAY;
			if (st_q.awaddr == `REG_CTRL) begin
				if (st_q.wstrb[0]) begin
					st_d.run = st_q.wdata[`CTRL_RUN_BIT];
				end
			end else if (st_q.awaddr == `REG_STAT || st_q.awaddr == `REG_WORD) begin
				st_d.bresp = `RESP_OKAY;
			end else if (st_q.awaddr != `REG_CYC) begin
				st_d.bresp = `RESP_SLVERR;
			end
		end else if (st_q.bvalid && axi_req.bready) begin
			st_d.bvalid = 1'b0;
		end
		// Bus read side
		if (axi_req.arvalid && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = `RESP_OKAY;
			st_d.rdata = 32'h0;
			if ({axi_req.araddr[7:2], 2'b00} == `REG_CTRL) begin
				st_d.rdata[`CTRL_RUN_BIT] = st_q.run;
			end else if ({axi_req.araddr[7:2], 2'b00} == `REG_STAT) begin
				st_d.rdata = {10'h0, st_q.ex.opcode, 12'h0, st_q.ex.grp, st_q.ex.idle, st_q.flush};
			end else if ({axi_req.araddr[7:2], 2'b00} == `REG_WORD) begin
				st_d.rdata = {18'h0, st_q.last_w};
			end else if ({axi_req.araddr[7:2], 2'b00} == `REG_CYC) begin
				st_d.rdata = st_q.cyc;
			end else begin
				st_d.rresp = `RESP_SLVERR;
			end
		end else if (st_q.rvalid && axi_req.rready) begin
			st_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.run <= `CTRL_RUN_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// Outputs
	assign ex = st_q.ex;
	always_comb begin
		axi_rsp.awready = !st_q.aw_got && !st_q.bvalid;
		axi_rsp.wready = !st_q.w_got && !st_q.bvalid;
		axi_rsp.bvalid = st_q.bvalid;
		axi_rsp.bresp = st_q.bresp;
		axi_rsp.arready = !st_q.rvalid;
		axi_rsp.rvalid = st_q.rvalid;
		axi_rsp.rdata = st_q.rdata;
		axi_rsp.rresp = st_q.rresp;
	end

	// ==========================================
	// Checks
	AST_FOUR_PERIODS: assert property (@(posedge clk) disable iff (!rst_n)
		tick ##1 st_q.run [*3] |-> !tick ##0 $past(tick, 3));
	AST_IDLE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !st_q.flush && (pc_chg || skip_taken) |=> st_q.flush ##0
		(!tick [*3]) ##1 (!tick || (st_d.ex.idle && !st_d.flush)));
	AST_STATUS_WIPE: assert property (@(posedge clk) disable iff (!rst_n)
		ex.valid && !ex.idle && ex.opcode == 6'b000001 && ex.to_file &&
		ex.reg_num == `ADDR_STATUS |-> ex.wr_data == 8'h04);
	AST_DEST_ACC: assert property (@(posedge clk) disable iff (!rst_n)
		ex.valid && !ex.idle && ex.grp == GRP_BYTE |->
		ex.wr_file == ex.to_file && !(ex.wr_file && ex.acc_wr));
	AST_BYTE_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !st_q.flush |=> ex.reg_num == $past(fetch_word[6:0]) &&
		ex.opcode == $past(fetch_word[13:8]) && ex.to_file == $past(fetch_word[7]));
	AST_BIT_POS: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !st_q.flush && fetch_word[13:12] == 2'b01 |=>
		ex.flag_pos == $past(fetch_word[9:7]) && ex.grp == GRP_BIT);
	AST_LONG_IMM: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !st_q.flush && fetch_word[13:12] == 2'b10 |=>
		ex.imm11 == $past(fetch_word[10:0]) && ex.two_cycle);
	AST_BIT_RMW: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !st_q.flush && fetch_word[13:11] == 3'b010 &&
		fetch_word[6:0] != `ADDR_STATUS |=> ex.wr_file && (ex.wr_data ==
		(($past(file_rd_data) & ~(8'h01 << ex.flag_pos)) |
		({7'h0, ex.opcode[2]} << ex.flag_pos))));
	AST_BRESP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp));

endmodule

`default_nettype wire

// *** design/isa_defines.svh ***
// Offsets, field positions, reset values and counts for the instruction decoder
`ifndef ISA_DEFINES_SVH
`define ISA_DEFINES_SVH

// ==========================================
// Register map (byte addresses)
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_WORD 8'h08
`define REG_CYC 8'h0c
`define CTRL_RUN_BIT 0
`define CTRL_RUN_RST 1'b1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ==========================================
// Instruction fields
`define INSN_W 14
`define OP_HI 13
`define OP_LO 8
`define DEST_BIT 7
`define REG_HI 6
`define POS_HI 9
`define POS_LO 7
`define IMM8_HI 7
`define IMM11_HI 10

// ==========================================
// File addresses and status flag positions
`define ADDR_PCL 7'h02
`define ADDR_STATUS 7'h03
`define FLAG_Z 2
`define FLAG_DC 1
`define FLAG_C 0

// ==========================================
// Timing
`define OSC_PER_INSN 4

`endif

// *** design/isa_pkg.sv ***
// Types shared by the instruction decoder and its bench
package isa_pkg;

	typedef enum logic [1:0] {GRP_BYTE = 2'b00, GRP_BIT = 2'b01, GRP_LIT = 2'b10} grp_t;

	// Gray order along the oscillator phases
	typedef enum logic [1:0] {PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b11, PH_Q4 = 2'b10} phase_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;

	typedef struct packed {
		logic valid;
		logic idle;
		grp_t grp;
		logic [5:0] opcode;
		logic to_file;
		logic [6:0] reg_num;
		logic [2:0] flag_pos;
		logic [7:0] imm8;
		logic [10:0] imm11;
		logic wr_file;
		logic acc_wr;
		logic [7:0] wr_data;
		logic two_cycle;
	} exec_t;

	typedef struct packed {
		phase_t ph;
		logic run;
		logic flush;
		logic [31:0] cyc;
		logic [13:0] last_w;
		exec_t ex;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

endpackage

// *** testbench/prog_mem.sv ***
// Program memory model feeding instruction words
`timescale 1ns/10ps
`default_nettype none

module prog_mem (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fetch_take,
	output logic [13:0] fetch_word
);
	logic [13:0] mem [64];
	logic [5:0] ptr;

	// Word held only on the take cycle, so a late sample sees garbage
	assign fetch_word = fetch_take ? mem[ptr] : ~mem[ptr];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr <= 6'h00;
		end else if (fetch_take) begin
			ptr <= ptr + 6'h01;
		end
	end

	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 14'h0000;
		end
	end
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import isa_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	axi_req_t req = '0;
	axi_rsp_t rsp;
	logic [13:0] fw;
	logic ft;
	logic [6:0] ra;
	logic [7:0] frd = 8'h00;
	logic [7:0] alu = 8'h00;
	logic [2:0] flg = 3'h0;
	exec_t ex;
	int err_total = 0;
	int tests_run = 0;
	int n;
	logic [31:0] rd;
	logic [1:0] rr;

	always #20 clk = ~clk;

	risc_instruction_format_decoder dut (.clk(clk), .arst_n(arst_n), .axi_req(req),
		.axi_rsp(rsp), .fetch_word(fw), .fetch_take(ft), .rd_addr(ra),
		.file_rd_data(frd), .alu_result(alu), .alu_flags(flg), .ex(ex));
	prog_mem pm (.clk(clk), .arst_n(arst_n), .fetch_take(ft), .fetch_word(fw));

	// ==========================================
	// Shared tasks
	task automatic conclude();
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stuck(input string nm);
		err_total++;
		$display("ERROR %s expected handshake seen timeout", nm);
		conclude();
	endtask

	// Counts edges up to and including the next take edge; pulse seen off the edge
	task automatic sync_take(output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (ft !== 1'b1 && c < 9);
		if (c >= 9) stuck("fetch_take");
		@(posedge clk);
		c++;
	endtask

	// Valid stands only in the cycle after the take edge
	task automatic wait_exec();
		int c;
		sync_take(c);
		#1;
		chk("ex.valid", 32'h1, ex.valid);
	endtask

	// Copies fill the next slots so stray fetches repeat the same word
	task automatic run_word(input logic [13:0] w, input logic [7:0] f, input logic [7:0] a);
		@(posedge clk);
		frd <= f;
		alu <= a;
		#1;
		for (int k = 0; k < 4; k++) begin
			pm.mem[6'(pm.ptr + k)] = w;
		end
		wait_exec();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 20);
		rr = rsp.bresp;
		req.bready <= 1'b0;
		if (n >= 20) stuck("bvalid");
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 20);
		rd = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
		if (n >= 20) stuck("rvalid");
	endtask

	// ==========================================
	// Scenarios
	task automatic t_byte();
		run_word(14'h07a5, 8'h00, 8'h3c);
		chk("opcode", 32'h07, ex.opcode);
		chk("reg_num", 32'h25, ex.reg_num);
		chk("wr_file", 32'h1, ex.wr_file);
		chk("acc_wr", 32'h0, ex.acc_wr);
		chk("wr_data", 32'h3c, ex.wr_data);
		run_word(14'h077f, 8'h00, 8'h5a);
		chk("reg_num top", 32'h7f, ex.reg_num);
		chk("to_file", 32'h0, ex.to_file);
		chk("acc_wr d0", 32'h1, ex.acc_wr);
		$display("t_byte done");
	endtask

	task automatic t_bit();
		run_word(14'h1690, 8'h00, 8'h00);
		chk("flag_pos", 32'h5, ex.flag_pos);
		chk("grp", GRP_BIT, ex.grp);
		chk("set data", 32'h20, ex.wr_data);
		run_word(14'h107f, 8'hff, 8'h00);
		chk("clear data", 32'hfe, ex.wr_data);
		$display("t_bit done");
	endtask

	task automatic t_lit();
		run_word(14'h33a5, 8'h00, 8'ha5);
		chk("imm8", 32'ha5, ex.imm8);
		chk("lit acc", 32'h1, ex.acc_wr);
		chk("lit two", 32'h0, ex.two_cycle);
		axi_rd(8'h08);
		chk("last word", 32'h33a5, rd);
		run_word(14'h0060, 8'h00, 8'h00);
		chk("idle x", 32'h1, ex.idle);
		$display("t_lit done");
	endtask

	task automatic t_stat();
		flg <= 3'h4;
		run_word(14'h0183, 8'h55, 8'h00);
		chk("status reg", 32'h03, ex.reg_num);
		chk("status data", 32'h04, ex.wr_data);
		$display("t_stat done");
	endtask

	task automatic t_jump();
		int c;
		run_word(14'h2da3, 8'h00, 8'h00);
		chk("imm11", 32'h5a3, ex.imm11);
		chk("two_cycle", 32'h1, ex.two_cycle);
		wait_exec();
		chk("flush idle", 32'h1, ex.idle);
		chk("flush op", 32'h0, ex.imm11);
		sync_take(c);
		sync_take(c);
		chk("take spacing", 32'h4, c);
		$display("t_jump done");
	endtask

	task automatic t_bus();
		axi_rd(8'h10);
		chk("unmapped resp", 32'h2, rr);
		chk("unmapped data", 32'h0, rd);
		axi_wr(8'h0c, 32'h0000_00ff);
		chk("ro write resp", 32'h0, rr);
		axi_wr(8'h00, 32'h0);
		n = 0;
		repeat (12) begin
			@(posedge clk);
			if (ft !== 1'b0) n++;
		end
		chk("halted takes", 32'h0, n);
		axi_rd(8'h00);
		chk("ctrl", 32'h0, rd);
		axi_wr(8'h00, 32'h1);
		$display("t_bus done");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_byte();
		t_bit();
		t_lit();
		t_stat();
		t_jump();
		t_bus();
		conclude();
	end
endmodule

`default_nettype wire
